// File: core/slc_top.sv
// Notes on behaviour
// - Register fifteen doubles as stack pointer.
// - Pointer holds next free word, grows upward.
// - Push writes then increments; pop decrements first.
// - Call push zero-extends upper counter part.
// - Exception push adds status low byte.
// - Limit register untouched by any reset.
// - Limit bit zero always reads zero.
// - Pointer-based addresses compared against limit.
// - Push at limit passes; next push traps.
// - Address below data RAM start traps.
module slc_top
   import slc_pkg::*;
(
   input  wire logic                  clk_in,
   input  wire logic                  rstn_in,
   // Avalon-MM slave
   input  wire logic [SLC_ADDR_W-1:0] avs_address_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [31:0]           avs_writedata_in,
   output logic      [31:0]           avs_readdata_out,
   output logic                       avs_waitrequest_out,
   // Core side
   input  wire logic                  push_in,
   input  wire slc_push_kind_t        push_kind_in,
   input  wire logic [15:0]           push_data_in,
   input  wire logic [SLC_PCH_W-1:0]  pc_high_in,
   input  wire logic [SLC_SRL_W-1:0]  status_low_byte_in,
   input  wire logic                  pop_in,
   input  wire logic                  ea_valid_in,
   input  wire logic [15:0]           ea_addr_in,
   input  wire logic                  wreg_wr_in,
   input  wire logic [15:0]           wreg_wr_data_in,
   output logic      [15:0]           stack_pointer_out,
   output logic      [15:0]           stack_limit_out,
   output logic                       stack_wr_en_out,
   output logic      [15:0]           stack_wr_addr_out,
   output logic      [15:0]           stack_wr_data_out,
   output logic                       stack_rd_en_out,
   output logic      [15:0]           stack_rd_addr_out,
   output logic                       stack_trap_out,
   output logic                       stack_overflow_out,
   output logic                       stack_underflow_out,
   output logic                       irq_out
);

   slc_state_t q;
   slc_state_t d;

   logic              bus_req;
   logic              bus_wr;
   logic [15:0]       wdata16;
   logic [15:0]       chk_addr;
   logic              chk_valid;
   logic              ovf_ev;
   logic              unf_ev;
   logic [SLC_EV_N-1:0] ev;

   // Bus handshake: one wait cycle, then the answer
   assign bus_req = avs_read_in | avs_write_in;
   assign bus_wr  = avs_write_in & q.ack;
   assign wdata16 = avs_writedata_in[15:0];

   // Address under check: push uses pointer, pop uses pointer minus a word
   always_comb begin
      chk_valid = 1'b0;
      chk_addr  = q.sp;
      if (push_in) begin
         chk_valid = 1'b1;
         chk_addr  = q.sp;
      end else if (pop_in) begin
         chk_valid = 1'b1;
         chk_addr  = q.sp - SLC_WORD_STEP;
      end else if (ea_valid_in) begin
         chk_valid = 1'b1;
         chk_addr  = ea_addr_in;
      end
   end

   // limit written by bus is used from the next cycle on
   assign ovf_ev = chk_valid & (push_in | ea_valid_in) & (chk_addr > q.lim);
   assign unf_ev = chk_valid & (chk_addr < SLC_RAM_START);
   assign ev     = {unf_ev, ovf_ev};

   // Next state
   always_comb begin
      d       = q;
      d.trap  = 1'b0;
      d.ovf   = 1'b0;
      d.unf   = 1'b0;
      d.wr_en = 1'b0;
      d.rd_en = 1'b0;

      // Bus answer timing
      d.ack = bus_req & ~q.ack;
      if (bus_req & ~q.ack) begin
         case (avs_address_in)
            SLC_SP_ADDR:      d.rdata = q.sp;
            SLC_LIM_ADDR:     d.rdata = q.lim;
            SLC_IRQ_STS_ADDR: d.rdata = {{(16-SLC_EV_N){1'b0}}, q.sts};
            SLC_IRQ_EN_ADDR:  d.rdata = {{(16-SLC_EV_N){1'b0}}, q.en};
            default:          d.rdata = SLC_UNMAPPED_RD[15:0];
         endcase
      end

      // Bus writes to registers
      if (bus_wr) begin
         case (avs_address_in)
            SLC_SP_ADDR:      d.sp = wdata16;
            SLC_LIM_ADDR:     d.lim = {wdata16[15:1], 1'b0};
            SLC_IRQ_CLR_ADDR: d.sts = q.sts & ~wdata16[SLC_EV_N-1:0];
            SLC_IRQ_EN_ADDR:  d.en = wdata16[SLC_EV_N-1:0];
            default:          d.en = q.en;
         endcase
      end

      // core writes as ordinary working register
      if (wreg_wr_in) begin
         d.sp = wreg_wr_data_in;
      end else if (push_in) begin
         // grows upward, points at next free word
         d.wr_en   = 1'b1;
         d.wr_addr = q.sp;
         d.sp      = q.sp + SLC_WORD_STEP;
         case (push_kind_in)
            SLC_PUSH_CALL: d.wr_data = {{(16-SLC_PCH_W){1'b0}}, pc_high_in};
            // status low byte beside counter upper part
            SLC_PUSH_EXC:  d.wr_data = {status_low_byte_in, 1'b0, pc_high_in};
            default:       d.wr_data = push_data_in;
         endcase
      end else if (pop_in) begin
         d.rd_en   = 1'b1;
         d.rd_addr = q.sp - SLC_WORD_STEP;
         d.sp      = q.sp - SLC_WORD_STEP;
      end

      // one-cycle trap on a qualified access
      d.trap = ovf_ev | unf_ev;
      d.ovf  = ovf_ev;
      d.unf  = unf_ev;
      // Set wins over clear
      d.sts  = d.sts | ev;

      // reset leaves limit as it was
      if (!rstn_in) begin
         d       = '0;
         d.sp    = SLC_SP_RESET;
         d.lim   = q.lim;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      q <= d;
   end

   // Outputs
   assign avs_waitrequest_out = bus_req & ~q.ack;
   assign avs_readdata_out    = {16'h0000, q.rdata};
   assign stack_pointer_out   = q.sp;
   assign stack_limit_out     = q.lim;
   assign stack_wr_en_out     = q.wr_en;
   assign stack_wr_addr_out   = q.wr_addr;
   assign stack_wr_data_out   = q.wr_data;
   assign stack_rd_en_out     = q.rd_en;
   assign stack_rd_addr_out   = q.rd_addr;
   assign stack_trap_out      = q.trap;
   assign stack_overflow_out  = q.ovf;
   assign stack_underflow_out = q.unf;
   assign irq_out             = |(q.sts & q.en);

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_push_plain;
      push_in && !wreg_wr_in;
   endsequence

   sequence s_pop_plain;
      pop_in && !push_in && !wreg_wr_in;
   endsequence

   a_wreg_write_sp: assert property (
      wreg_wr_in |=> stack_pointer_out == $past(wreg_wr_data_in))
      else $error("working register write lost");

   a_push_grows_up: assert property (
      s_push_plain |=> stack_pointer_out == $past(stack_pointer_out) + SLC_WORD_STEP
                       && stack_wr_addr_out == $past(stack_pointer_out) && stack_wr_en_out)
      else $error("push did not post-increment");

   a_pop_predec: assert property (
      s_pop_plain |=> stack_rd_en_out && stack_rd_addr_out == $past(stack_pointer_out) - SLC_WORD_STEP
                      && stack_pointer_out == stack_rd_addr_out)
      else $error("pop did not pre-decrement");

   a_call_zero_ext: assert property (
      s_push_plain ##0 push_kind_in == SLC_PUSH_CALL |=> stack_wr_data_out[15:SLC_PCH_W] == '0
                      && stack_wr_data_out[SLC_PCH_W-1:0] == $past(pc_high_in))
      else $error("call push not zero-extended");

   a_exc_status_byte: assert property (
      s_push_plain ##0 push_kind_in == SLC_PUSH_EXC |=> stack_wr_data_out[15:8] == $past(status_low_byte_in)
                      && !stack_wr_data_out[7] && stack_wr_data_out[SLC_PCH_W-1:0] == $past(pc_high_in))
      else $error("exception push lacks status byte");

   a_data_push: assert property (
      s_push_plain ##0 push_kind_in == SLC_PUSH_DATA |=> stack_wr_data_out == $past(push_data_in))
      else $error("pushed data word wrong");

   // Pulses only follow the request that caused them
   a_wr_pulse_cause: assert property (
      stack_wr_en_out |-> $past(push_in) && !$past(wreg_wr_in))
      else $error("write pulse without push");

   a_rd_pulse_cause: assert property (
      stack_rd_en_out |-> $past(pop_in) && !$past(push_in) && !$past(wreg_wr_in))
      else $error("read pulse without pop");

   a_sp_after_reset: assert property (
      $rose(rstn_in) |-> stack_pointer_out == SLC_SP_RESET && !stack_trap_out)
      else $error("pointer not at data RAM start after reset");

   a_bus_write_sp: assert property (
      bus_wr && avs_address_in == SLC_SP_ADDR && !wreg_wr_in && !push_in && !pop_in
      |=> stack_pointer_out == $past(wdata16))
      else $error("bus pointer write lost");

   a_limit_aligned: assert property (
      bus_wr && avs_address_in == SLC_LIM_ADDR |=> !stack_limit_out[0])
      else $error("limit bit zero set");

   sequence s_push_at_limit;
      push_in && stack_pointer_out == stack_limit_out;
   endsequence

   a_limit_equal_ok: assert property (
      s_push_at_limit |=> !stack_overflow_out)
      else $error("push at limit trapped");

   a_push_over_limit: assert property (
      push_in && stack_pointer_out > stack_limit_out |=> stack_overflow_out && stack_trap_out)
      else $error("push past limit missed");

   a_ea_overflow: assert property (
      ea_valid_in && !push_in && !pop_in && ea_addr_in > stack_limit_out
      |=> stack_overflow_out)
      else $error("pointer address over limit missed");

   a_ea_in_range: assert property (
      ea_valid_in && !push_in && !pop_in && ea_addr_in <= stack_limit_out && ea_addr_in >= SLC_RAM_START
      |=> !stack_trap_out)
      else $error("pointer address in range trapped");

   a_underflow_trap: assert property (
      push_in && stack_pointer_out < SLC_RAM_START |=> stack_underflow_out && stack_trap_out)
      else $error("underflow not trapped");

   a_pop_underflow: assert property (
      s_pop_plain ##0 stack_pointer_out >= SLC_WORD_STEP && stack_pointer_out < SLC_RAM_START + SLC_WORD_STEP
      |=> stack_underflow_out && stack_trap_out)
      else $error("pop below data RAM start not trapped");

   a_ea_underflow: assert property (
      ea_valid_in && !push_in && !pop_in && ea_addr_in < SLC_RAM_START
      |=> stack_underflow_out && stack_trap_out)
      else $error("pointer address below data RAM missed");

   a_trap_pulse: assert property (
      stack_trap_out |-> $past(push_in) || $past(pop_in) || $past(ea_valid_in))
      else $error("trap without access");

   a_trap_one_cycle: assert property (
      stack_trap_out && !push_in && !pop_in && !ea_valid_in |=> !stack_trap_out)
      else $error("trap longer than one cycle");

   // Sticky status: set wins over a clear in the same cycle
   a_status_ovf_set: assert property (
      stack_overflow_out |-> q.sts[SLC_EV_OVF])
      else $error("overflow status not set");

   a_status_unf_set: assert property (
      stack_underflow_out |-> q.sts[SLC_EV_UNF])
      else $error("underflow status not set");

   a_status_clear: assert property (
      bus_wr && avs_address_in == SLC_IRQ_CLR_ADDR && wdata16[SLC_EV_OVF] && !ovf_ev
      |=> !q.sts[SLC_EV_OVF])
      else $error("overflow status not cleared");

   a_bus_answer: assert property (
      $rose(avs_waitrequest_out) |=> !avs_waitrequest_out)
      else $error("bus answer late");

endmodule // slc_top

// File: core/slc_pkg.sv
package slc_pkg;

   // Register indices; the bus byte address is four times the index
   localparam logic [15:0] SLC_SP_IDX       = 16'h001e;
   localparam logic [15:0] SLC_LIM_IDX      = 16'h0020;
   localparam logic [15:0] SLC_IRQ_STS_IDX  = 16'h0022;
   localparam logic [15:0] SLC_IRQ_CLR_IDX  = 16'h0024;
   localparam logic [15:0] SLC_IRQ_EN_IDX   = 16'h0026;
   localparam int          SLC_ADDR_W       = 8;
   localparam int          SLC_IDX_SCALE    = 4;

   // Byte addresses seen on the bus
   localparam logic [7:0] SLC_SP_ADDR      = 8'(SLC_SP_IDX * SLC_IDX_SCALE);
   localparam logic [7:0] SLC_LIM_ADDR     = 8'(SLC_LIM_IDX * SLC_IDX_SCALE);
   localparam logic [7:0] SLC_IRQ_STS_ADDR = 8'(SLC_IRQ_STS_IDX * SLC_IDX_SCALE);
   localparam logic [7:0] SLC_IRQ_CLR_ADDR = 8'(SLC_IRQ_CLR_IDX * SLC_IDX_SCALE);
   localparam logic [7:0] SLC_IRQ_EN_ADDR  = 8'(SLC_IRQ_EN_IDX * SLC_IDX_SCALE);

   // Reset values and address bounds
   localparam logic [15:0] SLC_SP_RESET    = 16'h0800;
   localparam logic [15:0] SLC_RAM_START   = 16'h0800;
   localparam logic [15:0] SLC_WORD_STEP   = 16'h0002;
   localparam logic [31:0] SLC_UNMAPPED_RD = 32'h0000_0000;

   // Interrupt status bit positions
   localparam int SLC_EV_OVF = 0;
   localparam int SLC_EV_UNF = 1;
   localparam int SLC_EV_N   = 2;

   // Stacked word layout for program counter pushes
   localparam int SLC_PCH_W = 7;
   localparam int SLC_SRL_W = 8;

   // What a push carries
   typedef enum logic [1:0] {
      SLC_PUSH_DATA,
      SLC_PUSH_CALL,
      SLC_PUSH_EXC
   } slc_push_kind_t;

   // Whole state of the checker
   typedef struct packed {
      logic [15:0]         sp;
      logic [15:0]         lim;
      logic [SLC_EV_N-1:0] sts;
      logic [SLC_EV_N-1:0] en;
      logic                ack;
      logic [15:0]         rdata;
      logic                trap;
      logic                ovf;
      logic                unf;
      logic                wr_en;
      logic [15:0]         wr_addr;
      logic [15:0]         wr_data;
      logic                rd_en;
      logic [15:0]         rd_addr;
   } slc_state_t;

endpackage // slc_pkg

// File: tb/slc_core_model.sv
// Core side: push, pop, pointer addresses, register writes
module slc_core_model
   import slc_pkg::*;
(
   input  wire logic                 clk_in,
   output logic                      push_out,
   output slc_push_kind_t            kind_out,
   output logic [15:0]               data_out,
   output logic [SLC_PCH_W-1:0]      pch_out,
   output logic [SLC_SRL_W-1:0]      srl_out,
   output logic                      pop_out,
   output logic                      ea_out,
   output logic                      wreg_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle lines at time zero
   initial begin
      {push_out, pop_out, ea_out, wreg_out} = 4'h0;
      kind_out = SLC_PUSH_DATA;
      {data_out, pch_out, srl_out} = '0;
   end

   // One request, held for exactly one taking edge
   task automatic step(input logic [3:0] op, input slc_push_kind_t k, input logic [15:0] v);
      {push_out, pop_out, ea_out, wreg_out} <= op;
      kind_out <= k;
      data_out <= v;
      pch_out  <= v[SLC_PCH_W-1:0];
      srl_out  <= v[15:8];
      @(posedge clk_in);
      {push_out, pop_out, ea_out, wreg_out} <= 4'h0;
      // Released data lines show the inverse; kind_out keeps its stale value
      data_out <= ~v;
      pch_out  <= ~v[SLC_PCH_W-1:0];
      srl_out  <= ~v[15:8];
   endtask
endmodule // slc_core_model

// File: tb/slc_top_tb.sv
module slc_top_tb
   import slc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [7:0]           avs_address_in;
   logic [31:0]          avs_writedata_in, avs_readdata_out, rd;
   logic                 push_in, pop_in, ea_valid_in, wreg_wr_in, we, re, trap, ovf, unf, irq;
   slc_push_kind_t       push_kind_in;
   logic [15:0]          cdata, sp_o, lim_o, wa, wd, ra;
   logic [SLC_PCH_W-1:0] pch;
   logic [SLC_SRL_W-1:0] status_low_byte;
   int                   mismatches, n_tests, cyc;

   slc_top dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .push_in(push_in), .push_kind_in(push_kind_in),
      .push_data_in(cdata), .pc_high_in(pch), .status_low_byte_in(status_low_byte), .pop_in(pop_in),
      .ea_valid_in(ea_valid_in), .ea_addr_in(cdata), .wreg_wr_in(wreg_wr_in), .wreg_wr_data_in(cdata),
      .stack_pointer_out(sp_o), .stack_limit_out(lim_o), .stack_wr_en_out(we), .stack_wr_addr_out(wa),
      .stack_wr_data_out(wd), .stack_rd_en_out(re), .stack_rd_addr_out(ra), .stack_trap_out(trap),
      .stack_overflow_out(ovf), .stack_underflow_out(unf), .irq_out(irq));

   slc_core_model u_core (
      .clk_in(clk_in), .push_out(push_in), .kind_out(push_kind_in), .data_out(cdata), .pch_out(pch),
      .srl_out(status_low_byte), .pop_out(pop_in), .ea_out(ea_valid_in), .wreg_out(wreg_wr_in));

   // Clock and hang guard
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Bus cycle held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      avs_write_in <= wr;
      avs_read_in <= !wr;
      avs_address_in <= a;
      avs_writedata_in <= {16'h0000, d};
      // Sampled at each rising edge; only the hang guard ends a wait
      do begin
         @(posedge clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      bus(1'b0, a, 16'h0000);
      chk(rd, {16'h0000, exp});
   endtask

   // Core request, then its one-cycle answer and trap flags
   task automatic op(input logic [3:0] o, input slc_push_kind_t k, input logic [15:0] v, input logic [2:0] fl);
      @(posedge clk_in);
      u_core.step(o, k, v);
      @(negedge clk_in);
      chk({trap, ovf, unf}, fl);
   endtask

   task automatic t_regs();
      rdchk(SLC_SP_ADDR, 16'h0800);
      rdchk(SLC_IRQ_STS_ADDR, 16'h0000);
      rdchk(SLC_IRQ_EN_ADDR, 16'h0000);
      rdchk(8'h04, 16'h0000);
      bus(1'b1, SLC_LIM_ADDR, 16'h0fff);
      rdchk(SLC_LIM_ADDR, 16'h0ffe);
      chk(lim_o, 16'h0ffe);
      @(posedge clk_in);
      rstn_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      rstn_in <= 1'b1;
      rdchk(SLC_LIM_ADDR, 16'h0ffe);
      $display("test regs done");
   endtask

   task automatic t_push();
      bus(1'b1, SLC_SP_ADDR, 16'h0ffa);
      op(4'h8, SLC_PUSH_DATA, 16'h1234, 3'b000);
      chk({we, wa, wd}, {1'b1, 16'h0ffa, 16'h1234});
      chk(sp_o, 16'h0ffc);
      op(4'h8, SLC_PUSH_CALL, 16'hffff, 3'b000);
      chk(wd, 16'h007f);
      op(4'h8, SLC_PUSH_EXC, 16'ha5ff, 3'b000);
      chk({wa, wd}, {16'h0ffe, 16'ha57f});
      op(4'h8, SLC_PUSH_DATA, 16'h0001, 3'b110);
      op(4'h0, SLC_PUSH_DATA, 16'h0000, 3'b000);
      rdchk(SLC_IRQ_STS_ADDR, 16'h0001);
      chk(irq, 1'b0);
      bus(1'b1, SLC_IRQ_EN_ADDR, 16'h0003);
      @(negedge clk_in);
      chk(irq, 1'b1);
      bus(1'b1, SLC_IRQ_CLR_ADDR, 16'h0001);
      @(negedge clk_in);
      chk(irq, 1'b0);
      $display("test push done");
   endtask

   task automatic t_pop();
      op(4'h1, SLC_PUSH_DATA, 16'h0804, 3'b000);
      chk(sp_o, 16'h0804);
      op(4'h4, SLC_PUSH_DATA, 16'h0000, 3'b000);
      chk({re, ra, sp_o}, {1'b1, 16'h0802, 16'h0802});
      op(4'h4, SLC_PUSH_DATA, 16'h0000, 3'b000);
      op(4'h4, SLC_PUSH_DATA, 16'h0000, 3'b101);
      op(4'h8, SLC_PUSH_DATA, 16'h5a5a, 3'b101);
      chk(sp_o, 16'h0800);
      rdchk(SLC_IRQ_STS_ADDR, 16'h0002);
      chk(irq, 1'b1);
      bus(1'b1, SLC_LIM_ADDR, 16'h0ffe);
      op(4'h2, SLC_PUSH_DATA, 16'h1000, 3'b110);
      op(4'h2, SLC_PUSH_DATA, 16'h0ffe, 3'b000);
      op(4'h2, SLC_PUSH_DATA, 16'h07ff, 3'b101);
      $display("test pop done");
   endtask

   // Main sequence
   initial begin
      {mismatches, n_tests, cyc} = '0;
      {rstn_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
      repeat (5) @(posedge clk_in);
      rstn_in <= 1'b1;
      t_regs();
      t_push();
      t_pop();
      complete_run();
   end
endmodule // slc_top_tb
